// ===== siw_wakeup.sv
// Functional notes
// - NMI, watchdog, unmasked interrupts or reset wake
// - PLL restored to pre-idle state on exit
// - interrupt wake resumes subclock operation
// - reset wake resumes normal mode as reset
// - control register mask bits block wakes
// - filtered input three never wakes
// - wake regardless of request priority
// - lower priority: wake, leave request pending
// - higher priority or NMI: wake and acknowledge
// - NMI wake branches regardless of enable
// - maskable: branch by priority if enabled
// - HALT gates only CPU core clock
// - IDLE1 keeps only oscillator, PLL and serial/timer clock
// - IDLE2 and setup stop PLL, derived clocks
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`include "siw_consts.svh"

module siw_wakeup (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic [`SIW_AW-1:0]        reg_addr,
  input  wire logic [`SIW_DW-1:0]        reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [`SIW_DW-1:0]        reg_rdata,
  input  wire logic                      halt_req,
  input  wire logic                      nmi_pin,
  input  wire logic                      watchdog_nonmaskable_request,
  input  wire logic [`SIW_EXT_N-1:0]     ext_irq_pin,
  input  wire logic [`SIW_EXT_N-1:0]     ext_irq_mask,
  input  wire logic [`SIW_PER_N-1:0]     per_irq_req,
  input  wire logic [`SIW_PER_N-1:0]     per_irq_mask,
  input  wire logic [`SIW_PRIO_W-1:0]    req_prio,
  input  wire logic [`SIW_PRIO_W-1:0]    srv_prio,
  input  wire logic                      in_service,
  input  wire logic                      global_ie,
  output siw_pkg::siw_clk_gate_t         clk_gate,
  output siw_pkg::siw_resume_t           resume,
  output siw_pkg::siw_state_t            pm_state
);
  import siw_pkg::*;

  logic [`SIW_DW-1:0]     power_save_control_reg;
  logic [1:0]             mode_sel;
  logic [`SIW_DW-1:0]     clk_ctl;
  logic                   pll_saved;
  logic [`SIW_CNT_W-1:0]  cnt;
  siw_state_t             state;
  siw_state_t             next_state;
  siw_clk_gate_t          next_gate;
  siw_resume_t            next_resume;
  logic [1:0]             nmi_sync;
  logic [1:0]             wdt_sync;
  logic [`SIW_EXT_N-1:0]  ext_meta;
  logic [`SIW_EXT_N-1:0]  ext_q;
  logic [`SIW_EXT_N-1:0]  ext_ok;
  logic                   nmi_source0_wake_mask;
  logic                   nmi_source1_wake_mask;
  logic                   maskable_wake_mask;
  logic                   filt3;
  logic                   nmi_wake;
  logic                   mi_wake;
  logic                   wake;
  logic                   psave;
  logic                   higher;
  logic                   stp_wr;

  assign nmi_source0_wake_mask = power_save_control_reg[`SIW_PWR_NMI0_MASK];
  assign nmi_source1_wake_mask = power_save_control_reg[`SIW_PWR_NMI1_MASK];
  assign maskable_wake_mask    = power_save_control_reg[`SIW_PWR_MI_MASK];
  assign filt3                 = clk_ctl[`SIW_CC_FILT3];
  assign pm_state              = state;

  // pins are asynchronous, two stages before any use
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      nmi_sync <= 2'h0;
      wdt_sync <= 2'h0;
      ext_meta <= '0;
      ext_q    <= '0;
    end else begin
      nmi_sync <= {nmi_sync[0], nmi_pin};
      wdt_sync <= {wdt_sync[0], watchdog_nonmaskable_request};
      ext_meta <= ext_irq_pin;
      ext_q    <= ext_meta;
    end
  end

  // noise filter on input three blocks it as a wake source
  always_comb begin
    ext_ok = ext_q & ~ext_irq_mask;
    ext_ok[`SIW_EXT_FILT_BIT] = ext_ok[`SIW_EXT_FILT_BIT] & ~filt3;
  end

  assign nmi_wake = (nmi_sync[1] & ~nmi_source0_wake_mask) |
                    (wdt_sync[1] & ~nmi_source1_wake_mask);
  assign mi_wake  = ~maskable_wake_mask &
                    ((|ext_ok) | (|(per_irq_req & ~per_irq_mask)));
  // priority plays no part in the release itself
  assign wake     = nmi_wake | mi_wake;

  assign psave  = (state == SIW_HALT) || (state == SIW_IDLE1) ||
                  (state == SIW_IDLE2) || (state == SIW_STOP) ||
                  (state == SIW_SUB_IDLE);
  assign higher = !in_service || (req_prio < srv_prio);
  assign stp_wr = reg_wr && (reg_addr == `SIW_ADDR_PWR) &&
                  reg_wdata[`SIW_PWR_STOP];

  // register writes; stp is a trigger and never stored
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_save_control_reg <= `SIW_PWR_RST;
      mode_sel               <= `SIW_MODE_RST;
    end else if (reg_wr && (reg_addr == `SIW_ADDR_PWR)) begin
      power_save_control_reg <= reg_wdata &
                                ~(8'h01 << `SIW_PWR_STOP);
    end else if (reg_wr && (reg_addr == `SIW_ADDR_MODE)) begin
      mode_sel <= reg_wdata[`SIW_MODE_HI:`SIW_MODE_LO];
    end
  end

  // clock control; pll bit restored when sub-idle ends
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_ctl   <= `SIW_CC_RST;
      pll_saved <= 1'b0;
    end else if (state == SIW_SUB_IDLE) begin
      if (wake) begin
        clk_ctl[`SIW_CC_PLL_ON] <= pll_saved;
      end
    end else if (reg_wr && (reg_addr == `SIW_ADDR_CLKCTL)) begin
      clk_ctl <= reg_wdata;
    end else begin
      pll_saved <= clk_ctl[`SIW_CC_PLL_ON];
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      SIW_RUN: begin
        if (clk_ctl[`SIW_CC_SUB_SEL]) begin
          next_state = SIW_SUB_RUN;
        end else if (stp_wr) begin
          unique case (mode_sel)
            `SIW_PSM_IDLE1: next_state = SIW_IDLE1;
            `SIW_PSM_IDLE2: next_state = SIW_IDLE2;
            default:        next_state = SIW_STOP;
          endcase
        end else if (halt_req) begin
          next_state = SIW_HALT;
        end
      end
      SIW_HALT, SIW_IDLE1: begin
        if (wake) begin
          next_state = SIW_RUN;
        end
      end
      SIW_IDLE2: begin
        if (wake) begin
          next_state = SIW_IDLE2_SETUP;
        end
      end
      SIW_IDLE2_SETUP, SIW_STOP_STAB: begin
        if (cnt == '0) begin
          next_state = SIW_RUN;
        end
      end
      SIW_STOP: begin
        if (wake) begin
          next_state = SIW_STOP_STAB;
        end
      end
      SIW_SUB_RUN: begin
        if (!clk_ctl[`SIW_CC_SUB_SEL]) begin
          next_state = SIW_RUN;
        end else if (stp_wr && (mode_sel == `SIW_PSM_IDLE2)) begin
          next_state = SIW_SUB_IDLE;
        end
      end
      SIW_SUB_IDLE: begin
        if (wake) begin
          next_state = SIW_SUB_RUN;
        end
      end
    endcase
  end

  // reset from any state lands in normal run, same as power-up
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= SIW_RUN;
    end else begin
      state <= next_state;
    end
  end

  // one shared recovery counter, loaded on the wake edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (state == SIW_IDLE2 && wake) begin
      cnt <= `SIW_CNT_W'(`SIW_SETUP_CYC - 1);
    end else if (state == SIW_STOP && wake) begin
      cnt <= `SIW_CNT_W'(`SIW_STAB_CYC - 1);
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  // gating follows next state so enables line up with the state
  always_comb begin
    next_gate = '1;
    next_gate.main_oscillator  = clk_ctl[`SIW_CC_MAIN_OSC_ON];
    next_gate.pll_output_clock = clk_ctl[`SIW_CC_PLL_ON];
    unique case (next_state)
      SIW_RUN, SIW_SUB_RUN: begin
      end
      SIW_HALT: begin
        next_gate.cpu_core_clock = 1'b0;
      end
      SIW_IDLE1: begin
        next_gate.main_system_clock          = 1'b0;
        next_gate.prescaler_peripheral_clock = 1'b0;
        next_gate.cpu_system_clock           = 1'b0;
        next_gate.cpu_core_clock             = 1'b0;
        next_gate.can_clock                  = 1'b0;
      end
      SIW_IDLE2, SIW_IDLE2_SETUP, SIW_STOP, SIW_STOP_STAB: begin
        next_gate = '0;
        next_gate.main_oscillator = (next_state != SIW_STOP) &&
                                    clk_ctl[`SIW_CC_MAIN_OSC_ON];
      end
      SIW_SUB_IDLE: begin
        next_gate = '0;
        next_gate.main_oscillator  = clk_ctl[`SIW_CC_MAIN_OSC_ON];
        // pll only runs if its oscillator does
        next_gate.pll_output_clock = pll_saved &&
                                     clk_ctl[`SIW_CC_MAIN_OSC_ON];
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_gate <= '0;
    end else begin
      clk_gate <= next_gate;
    end
  end

  // resume decision taken on the wake edge; an unacked request
  // stays pending in the interrupt controller
  always_comb begin
    next_resume = '0;
    if (psave && wake) begin
      next_resume.resume_sub = (state == SIW_SUB_IDLE);
      if (nmi_wake) begin
        next_resume.ack_nmi        = 1'b1;
        next_resume.branch_handler = 1'b1;
      end else if (global_ie && higher) begin
        next_resume.ack_maskable   = 1'b1;
        next_resume.branch_handler = 1'b1;
      end else begin
        next_resume.exec_next      = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resume <= '0;
    end else begin
      resume <= next_resume;
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `SIW_ADDR_PWR:    reg_rdata <= power_save_control_reg;
        `SIW_ADDR_MODE:   reg_rdata <= {6'h00, mode_sel};
        `SIW_ADDR_CLKCTL: reg_rdata <= clk_ctl;
        `SIW_ADDR_STATUS: reg_rdata <= {pll_saved, wake, 2'h0,
                                        4'(state)};
        default:          reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  AST_SUBIDLE_WAKE: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state == SIW_SUB_IDLE && wake) |=>
      (state == SIW_SUB_RUN && resume.resume_sub))
    else $error("sub-idle did not end on wake request");

  AST_SUBIDLE_MASKED: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state == SIW_SUB_IDLE && nmi_source0_wake_mask &&
     nmi_source1_wake_mask && maskable_wake_mask) |=>
      (state == SIW_SUB_IDLE))
    else $error("masked request released sub-idle");

  AST_FILT3_BLOCK: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    filt3 |-> !ext_ok[`SIW_EXT_FILT_BIT])
    else $error("filtered input three still qualifies");

  AST_PLL_RESTORE: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state == SIW_SUB_IDLE && wake) |=>
      (clk_ctl[`SIW_CC_PLL_ON] == $past(pll_saved)))
    else $error("pll state not restored after sub-idle");

  AST_HALT_GATE: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state == SIW_HALT) |->
      (!clk_gate.cpu_core_clock && clk_gate.main_system_clock &&
       clk_gate.prescaler_peripheral_clock &&
       clk_gate.cpu_system_clock && clk_gate.serial_timer_clock))
    else $error("halt gating wrong");

  AST_IDLE1_GATE: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state == SIW_IDLE1) |->
      (clk_gate.serial_timer_clock && !clk_gate.main_system_clock &&
       !clk_gate.cpu_core_clock && !clk_gate.can_clock &&
       !clk_gate.cpu_system_clock))
    else $error("idle1 gating wrong");

  AST_IDLE2_SETUP: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state == SIW_IDLE2 && wake) |=>
      (state == SIW_IDLE2_SETUP && !clk_gate.pll_output_clock &&
       !clk_gate.main_system_clock)[*8])
    else $error("pll or clocks running during idle2 setup");

  AST_NMI_BRANCH: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (psave && nmi_wake && !global_ie) |=>
      (resume.ack_nmi && resume.branch_handler && !resume.exec_next))
    else $error("nmi wake did not branch");

  AST_LOW_PRIO: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (psave && mi_wake && !nmi_wake && in_service &&
     req_prio >= srv_prio) |=>
      (!resume.ack_maskable && resume.exec_next))
    else $error("lower priority request acknowledged");

  AST_HIGH_PRIO: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (psave && mi_wake && !nmi_wake && global_ie && in_service &&
     req_prio < srv_prio) |=>
      (resume.ack_maskable && resume.branch_handler))
    else $error("higher priority request not acknowledged");

endmodule

// ===== siw_consts.svh
`ifndef SIW_CONSTS_SVH
`define SIW_CONSTS_SVH

// register port
`define SIW_AW              4
`define SIW_DW              8
`define SIW_ADDR_PWR        4'h0
`define SIW_ADDR_MODE       4'h4
`define SIW_ADDR_CLKCTL     4'h8
`define SIW_ADDR_STATUS     4'hc

// power_save_control_reg fields
`define SIW_PWR_STOP        1
`define SIW_PWR_MI_MASK     4
`define SIW_PWR_NMI0_MASK   5
`define SIW_PWR_NMI1_MASK   6
`define SIW_PWR_RST         8'h00

// mode register field
`define SIW_MODE_LO         0
`define SIW_MODE_HI         1
`define SIW_MODE_RST        2'h0
`define SIW_PSM_IDLE1       2'h0
`define SIW_PSM_STOP        2'h1
`define SIW_PSM_IDLE2       2'h2

// clock control fields
`define SIW_CC_PLL_ON       0
`define SIW_CC_SUB_SEL      1
`define SIW_CC_MAIN_OSC_ON  2
`define SIW_CC_FILT3        3
`define SIW_CC_RST          8'h05

// interrupt inputs
`define SIW_EXT_N           8
`define SIW_PER_N           16
`define SIW_PRIO_W          3
`define SIW_EXT_FILT_BIT    3

// timing
`define SIW_CLK_PERIOD_NS   4
`define SIW_SETUP_TIME_NS   1000
`define SIW_STAB_TIME_NS    2000
`define SIW_SETUP_CYC \
  ((`SIW_SETUP_TIME_NS + `SIW_CLK_PERIOD_NS - 1) / `SIW_CLK_PERIOD_NS)
`define SIW_STAB_CYC \
  ((`SIW_STAB_TIME_NS + `SIW_CLK_PERIOD_NS - 1) / `SIW_CLK_PERIOD_NS)
`define SIW_CNT_W           10

`endif

// ===== siw_pkg.sv
package siw_pkg;

  typedef enum logic [3:0] {
    SIW_RUN,
    SIW_HALT,
    SIW_IDLE1,
    SIW_IDLE2,
    SIW_IDLE2_SETUP,
    SIW_STOP,
    SIW_STOP_STAB,
    SIW_SUB_RUN,
    SIW_SUB_IDLE
  } siw_state_t;

  typedef struct packed {
    logic main_oscillator;
    logic pll_output_clock;
    logic main_system_clock;
    logic prescaler_peripheral_clock;
    logic cpu_system_clock;
    logic cpu_core_clock;
    logic serial_timer_clock;
    logic can_clock;
  } siw_clk_gate_t;

  typedef struct packed {
    logic ack_nmi;
    logic ack_maskable;
    logic branch_handler;
    logic exec_next;
    logic resume_sub;
  } siw_resume_t;

endpackage

// ===== siw_cpu_model.sv
`timescale 1ns/10ps
`include "siw_consts.svh"

module siw_cpu_model (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire siw_pkg::siw_resume_t   resume,
  input  wire logic [1:0]             ctl,
  input  wire logic [`SIW_PRIO_W-1:0] prio,
  output logic                        per_req,
  output logic                        in_service,
  output logic [`SIW_PRIO_W-1:0]      srv_prio
);
  import siw_pkg::*;
  // ctl: 1 raise, 2 enter handler at prio, 3 leave handler and drop
  // an unacked request stays up, as a real intc would hold it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      per_req    <= 1'b0;
      in_service <= 1'b0;
      srv_prio   <= '1;
    end else if (ctl == 2'h1) begin
      per_req <= 1'b1;
    end else if (ctl == 2'h2) begin
      in_service <= 1'b1;
      srv_prio   <= prio;
    end else if (ctl == 2'h3) begin
      per_req    <= 1'b0;
      in_service <= 1'b0;
    end else if (resume.ack_maskable && per_req) begin
      per_req    <= 1'b0;
      in_service <= 1'b1;
      srv_prio   <= prio;
    end
  end
endmodule

// ===== siw_wakeup_tb.sv
`timescale 1ns/10ps
`include "siw_consts.svh"

module siw_wakeup_tb;
  import siw_pkg::*;
  logic                   clk_sys;
  logic                   rst_n;
  logic [`SIW_AW-1:0]     reg_addr;
  logic [`SIW_DW-1:0]     reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [`SIW_DW-1:0]     reg_rdata;
  logic                   halt_req;
  logic                   nmi_pin;
  logic                   wdt;
  logic [`SIW_EXT_N-1:0]  ext_pin;
  logic [`SIW_EXT_N-1:0]  ext_mask;
  logic [`SIW_PER_N-1:0]  per_mask;
  logic                   per_req;
  logic [`SIW_PRIO_W-1:0] prio;
  logic [`SIW_PRIO_W-1:0] srv_prio;
  logic                   in_service;
  logic                   global_ie;
  logic [1:0]             ctl;
  logic [4:0]             seen;
  siw_clk_gate_t          clk_gate;
  siw_resume_t            resume;
  siw_state_t             pm_state;
  int                     fails;
  int                     n_checks;
  int                     cyc;
  int                     tcnt;
  logic [2:0]             rq [3] = '{3'h4, 3'h1, 3'h3};
  logic [2:0]             ex [3] = '{3'h1, 3'h6, 3'h1};

  siw_wakeup i_siw_wakeup (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .halt_req(halt_req), .nmi_pin(nmi_pin),
    .watchdog_nonmaskable_request(wdt), .ext_irq_pin(ext_pin),
    .ext_irq_mask(ext_mask),
    .per_irq_req({{(`SIW_PER_N-1){1'b0}}, per_req}),
    .per_irq_mask(per_mask), .req_prio(prio), .srv_prio(srv_prio),
    .in_service(in_service), .global_ie(global_ie),
    .clk_gate(clk_gate), .resume(resume), .pm_state(pm_state)
  );

  siw_cpu_model i_siw_cpu_model (
    .clk_sys(clk_sys), .rst_n(rst_n), .resume(resume), .ctl(ctl),
    .prio(prio), .per_req(per_req), .in_service(in_service),
    .srv_prio(srv_prio)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // sticky so that one-cycle resume pulses are never missed
  always @(posedge clk_sys) begin
    seen <= (ctl == 2'h3) ? 5'h0 : (seen | resume);
    tcnt <= tcnt + 1;
    if (tcnt == 20000) begin
      fails++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  task automatic cmd(input logic [1:0] c);
    @(posedge clk_sys);
    ctl <= c;
    @(posedge clk_sys);
    ctl <= 2'h0;
  endtask

  task automatic wst(input siw_state_t s, input int lim);
    cyc = 0;
    #1;
    while (pm_state !== s && cyc < lim) begin
      @(posedge clk_sys);
      #1 cyc++;
    end
    chk(8'(pm_state), 8'(s));
  endtask

  task automatic stay(input siw_state_t s);
    repeat (20) @(posedge clk_sys);
    #1 chk(8'(pm_state), 8'(s));
  endtask

  task automatic gc(input logic [7:0] e);
    repeat (2) @(posedge clk_sys);
    #1 chk(clk_gate, e);
  endtask

  task automatic sn(input logic [4:0] m, input logic [4:0] e);
    @(posedge clk_sys);
    #1 chk({3'h0, seen & m}, {3'h0, e});
  endtask

  task automatic sleep(input logic [7:0] m, input logic [7:0] p,
                       input siw_state_t s);
    cmd(2'h3);
    wr(`SIW_ADDR_MODE, m);
    wr(`SIW_ADDR_PWR, p | 8'h02);
    wst(s, 8);
  endtask

  initial begin
    {rst_n, reg_wr, reg_rd, halt_req, nmi_pin, wdt} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    ext_pin = '0;
    ext_mask = '0;
    per_mask = '0;
    prio = '0;
    global_ie = 1'b1;
    ctl = '0;
    seen = '0;
    {tcnt, fails, n_checks} = '0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rc(`SIW_ADDR_PWR, 8'h00);
    rc(`SIW_ADDR_MODE, 8'h00);
    rc(`SIW_ADDR_CLKCTL, 8'h05);
    rc(4'h2, 8'h00);
    rc(`SIW_ADDR_STATUS, 8'h80);
    chk(clk_gate, 8'hff);
    cmd(2'h3);
    @(posedge clk_sys) halt_req <= 1'b1;
    @(posedge clk_sys) halt_req <= 1'b0;
    wst(SIW_HALT, 8);
    gc(8'hfb);
    cmd(2'h1);
    wst(SIW_RUN, 20);
    sn(5'h08, 5'h08);
    sleep(8'h0, 8'h10, SIW_IDLE1);
    gc(8'hc2);
    cmd(2'h1);
    stay(SIW_IDLE1);
    @(posedge clk_sys) {global_ie, nmi_pin} <= 2'b01;
    wst(SIW_RUN, 20);
    sn(5'h14, 5'h14);
    @(posedge clk_sys) {global_ie, nmi_pin} <= 2'b10;
    sleep(8'h0, 8'h20, SIW_IDLE1);
    @(posedge clk_sys) nmi_pin <= 1'b1;
    stay(SIW_IDLE1);
    @(posedge clk_sys) wdt <= 1'b1;
    wst(SIW_RUN, 20);
    @(posedge clk_sys) {nmi_pin, wdt} <= 2'b00;
    sleep(8'h0, 8'h40, SIW_IDLE1);
    @(posedge clk_sys) {wdt, per_mask[0]} <= 2'b11;
    cmd(2'h1);
    stay(SIW_IDLE1);
    @(posedge clk_sys) {wdt, per_mask[0]} <= 2'b00;
    wst(SIW_RUN, 20);
    wr(`SIW_ADDR_CLKCTL, 8'h0d);
    sleep(8'h0, 8'h0, SIW_IDLE1);
    @(posedge clk_sys) ext_pin[3] <= 1'b1;
    stay(SIW_IDLE1);
    @(posedge clk_sys) {ext_mask[0], ext_pin[0]} <= 2'b11;
    stay(SIW_IDLE1);
    @(posedge clk_sys) ext_mask[0] <= 1'b0;
    wst(SIW_RUN, 20);
    @(posedge clk_sys) ext_pin <= '0;
    wr(`SIW_ADDR_CLKCTL, 8'h05);
    for (int i = 0; i < 3; i++) begin
      sleep(8'h0, 8'h0, SIW_IDLE1);
      @(posedge clk_sys) prio <= 3'h2;
      if (i < 2)
        cmd(2'h2);
      @(posedge clk_sys) {global_ie, prio} <= {i < 2, rq[i]};
      cmd(2'h1);
      wst(SIW_RUN, 20);
      sn(5'h0e, {1'b0, ex[i], 1'b0});
      chk({7'h0, per_req}, {7'h0, i != 1});
    end
    @(posedge clk_sys) global_ie <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      sleep(i ? 8'h1 : 8'h2, 8'h0, i ? SIW_STOP : SIW_IDLE2);
      gc(i ? 8'h00 : 8'h80);
      cmd(2'h1);
      wst(i ? SIW_STOP_STAB : SIW_IDLE2_SETUP, 20);
      gc(8'h80);
      wst(SIW_RUN, i ? 600 : 300);
      chk({7'h0, cyc >= (i ? 490 : 240)}, 8'h01);
    end
    for (int p = 0; p < 2; p++) begin
      wr(`SIW_ADDR_CLKCTL, 8'h06 | 8'(p));
      wst(SIW_SUB_RUN, 8);
      sleep(8'h2, 8'h0, SIW_SUB_IDLE);
      gc({1'b1, p[0], 6'h0});
      cmd(2'h1);
      wst(SIW_SUB_RUN, 20);
      sn(5'h01, 5'h01);
      rc(`SIW_ADDR_CLKCTL, 8'h06 | 8'(p));
    end
    sleep(8'h2, 8'h70, SIW_SUB_IDLE);
    cmd(2'h1);
    stay(SIW_SUB_IDLE);
    @(posedge clk_sys) rst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    wst(SIW_RUN, 4);
    rc(`SIW_ADDR_CLKCTL, 8'h05);
    gc(8'hff);
    test_done();
  end
endmodule
